/* rtl/scpi_status_group.v */
// One condition/transition/event/enable register group with its sum bit
`timescale 1ns/10ps
`include "status_event_reporting_consts.vh"
module scpi_status_group #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] USED = {WIDTH{1'b1}}
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] cond_in,
  input  wire             wr_enable,
  input  wire             wr_ptr,
  input  wire             wr_ntr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             rd_event,
  output reg  [WIDTH-1:0] cond,
  output reg  [WIDTH-1:0] event_bits,
  output reg  [WIDTH-1:0] enable,
  output reg  [WIDTH-1:0] ptr,
  output reg  [WIDTH-1:0] ntr,
  output wire             sum
);
  wire [WIDTH-1:0] next_cond;
  wire [WIDTH-1:0] rise;
  wire [WIDTH-1:0] fall;
  wire [WIDTH-1:0] hit;

  assign next_cond = cond_in & USED;
  assign rise      = next_cond & ~cond & ptr;
  assign fall      = ~next_cond & cond & ntr;
  assign hit       = rise | fall;
  assign sum       = |(event_bits & enable);

  always @(posedge core_clk) begin
    if (rst) begin
      cond       <= {WIDTH{1'b0}};
      event_bits <= {WIDTH{1'b0}};
      enable     <= {WIDTH{1'b0}};
      ptr        <= USED;
      ntr        <= {WIDTH{1'b0}};
    end else begin
      cond <= next_cond;
      // A new transition in the read cycle survives the clear
      if (rd_event)
        event_bits <= hit;
      else
        event_bits <= event_bits | hit;
      if (wr_enable)
        enable <= wr_data & USED;
      if (wr_ptr)
        ptr <= wr_data & USED;
      if (wr_ntr)
        ntr <= wr_data & USED;
    end
  end
endmodule

/* rtl/status_event_reporting.v */
// Status byte, event status and SCPI status registers with service request
//
// Operation
// - Event summary bit set when an enabled event status bit rises.
// - Operation complete set once every earlier command has finished after *OPC.
// - Query error set on read without query or abandoned response.
// - Device-dependent fault sets bit 3; error code -300..-399 or positive queued.
// - Execution error sets bit 4; error code -200..-300 queued.
// - Unknown or malformed command sets bit 5; code -100..-200 queued.
// - Handover from remote to local control sets bit 6.
// - Power up sets bit 7; bit 1 never used.
// - Event status register latches events; its query returns the contents.
// - Event status enable mask is stored with bit 1 cleared and read back as stored.
// - Questionable register fully unused; condition and event each readable.
// - Operation condition shows current activity; event latches since last read.
// - Operation condition bit 0 high throughout calibration; bits 1-2 unused.
// - Operation condition bit 3 high during any sweep; bits 4-15 unused.
// - Service request when status byte bit 2, 4 or 5 set and enabled.
// - Enable masks 1 and 32 make *OPC raise a service request.
// - Service request is the device's only self-initiated interaction.
// - Reading an event part clears it; enable and filter parts kept.
// - Rising condition needs positive filter; falling needs negative filter.
// - Bit 6 is the master summary of enabled bits; enable bit 6 ignored.
// - Bits 3 and 7 are OR of enabled questionable and operation events.
`timescale 1ns/10ps
`include "status_event_reporting_consts.vh"
module status_event_reporting (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        opc_request,
  input  wire        cmds_idle,
  input  wire        query_error,
  input  wire        device_error,
  input  wire        exec_error,
  input  wire        cmd_error,
  input  wire        go_local,
  input  wire        power_on,
  input  wire        err_queue_nonempty,
  input  wire        msg_available,
  input  wire        calibrating,
  input  wire        sweeping,
  input  wire        clear_status,
  input  wire        serial_poll,
  input  wire        wr_strobe,
  input  wire        rd_strobe,
  input  wire [3:0]  reg_sel,
  input  wire [15:0] wr_data,
  output reg  [15:0] rd_data,
  output reg         rd_valid,
  output reg         srq,
  output reg  [7:0]  status_byte,
  output reg         opc_pending
);
  reg  [7:0]  event_status;
  reg  [7:0]  event_status_enable;
  reg  [7:0]  srq_enable;
  reg  [7:0]  next_events;
  reg  [7:0]  next_status_byte;
  reg  [15:0] next_rd_data;
  wire        opc_done;
  wire        esr_read;
  wire        esb_sum;
  wire [15:0] ques_cond;
  wire [15:0] ques_event;
  wire [15:0] ques_enable;
  wire [15:0] ques_ptr;
  wire [15:0] ques_ntr;
  wire        ques_sum;
  wire [15:0] oper_cond;
  wire [15:0] oper_event;
  wire [15:0] oper_enable;
  wire [15:0] oper_ptr;
  wire [15:0] oper_ntr;
  wire        oper_sum;
  wire [15:0] oper_cond_in;

  wire [7:0]  srq_sources;
  reg         wr_ese;
  reg         wr_sre;
  reg         wr_ques_en;
  reg         wr_ques_ptr;
  reg         wr_ques_ntr;
  reg         wr_oper_en;
  reg         wr_oper_ptr;
  reg         wr_oper_ntr;
  reg         rd_ques_ev;
  reg         rd_oper_ev;

  // Writes to read-only or unmapped selectors decode to nothing
  always @* begin
    wr_ese      = 1'b0;
    wr_sre      = 1'b0;
    wr_ques_en  = 1'b0;
    wr_ques_ptr = 1'b0;
    wr_ques_ntr = 1'b0;
    wr_oper_en  = 1'b0;
    wr_oper_ptr = 1'b0;
    wr_oper_ntr = 1'b0;
    rd_ques_ev  = 1'b0;
    rd_oper_ev  = 1'b0;
    case (reg_sel)
      `SEL_ESE:         wr_ese      = wr_strobe;
      `SEL_SRE:         wr_sre      = wr_strobe;
      `SEL_QUES_EVENT:  rd_ques_ev  = rd_strobe;
      `SEL_QUES_ENABLE: wr_ques_en  = wr_strobe;
      `SEL_QUES_PTR:    wr_ques_ptr = wr_strobe;
      `SEL_QUES_NTR:    wr_ques_ntr = wr_strobe;
      `SEL_OPER_EVENT:  rd_oper_ev  = rd_strobe;
      `SEL_OPER_ENABLE: wr_oper_en  = wr_strobe;
      `SEL_OPER_PTR:    wr_oper_ptr = wr_strobe;
      `SEL_OPER_NTR:    wr_oper_ntr = wr_strobe;
      default:          wr_ese      = 1'b0;
    endcase
  end

  assign esr_read = rd_strobe && reg_sel == `SEL_ESR;

  // *OPC arms a wait; completion is only flagged with the command pipe empty
  assign opc_done = (opc_pending || opc_request) && cmds_idle;

  localparam [1:0] OPC_IDLE = 2'b01;
  localparam [1:0] OPC_WAIT = 2'b10;
  reg [1:0] opc_state;
  reg [1:0] next_opc_state;

  // Completion with the pipe already idle skips the wait state entirely
  always @* begin
    case (opc_state)
      OPC_IDLE: begin
        if (opc_request && !cmds_idle)
          next_opc_state = OPC_WAIT;
        else
          next_opc_state = OPC_IDLE;
      end
      OPC_WAIT: begin
        if (cmds_idle)
          next_opc_state = OPC_IDLE;
        else
          next_opc_state = OPC_WAIT;
      end
      default: next_opc_state = OPC_IDLE;
    endcase
    // A clear cancels a wait, but a new *OPC in the same cycle wins
    if (clear_status && !(opc_request && !cmds_idle))
      next_opc_state = OPC_IDLE;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      opc_state   <= OPC_IDLE;
      opc_pending <= 1'b0;
    end else begin
      opc_state   <= next_opc_state;
      opc_pending <= next_opc_state == OPC_WAIT;
    end
  end

  always @* begin
    next_events = 8'h00;
    next_events[`ESB_OP_COMPLETE]  = opc_done;
    next_events[`ESB_QUERY_ERROR]  = query_error;
    next_events[`ESB_DEVICE_ERROR] = device_error;
    next_events[`ESB_EXEC_ERROR]   = exec_error;
    next_events[`ESB_CMD_ERROR]    = cmd_error;
    next_events[`ESB_USER_REQUEST] = go_local;
    next_events[`ESB_POWER_ON]     = power_on;
    next_events = next_events & `ES_USED_MASK;
  end

  // Event memory: reading clears, but an event in the read cycle is kept
  always @(posedge core_clk) begin
    if (rst) begin
      event_status <= 8'h00;
    end else if (clear_status || esr_read) begin
      event_status <= next_events;
    end else begin
      event_status <= event_status | next_events;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      event_status_enable <= `RESET_ENABLE8;
      srq_enable          <= `RESET_ENABLE8;
    end else begin
      if (wr_ese)
        event_status_enable <= wr_data[7:0] & `ES_USED_MASK;
      if (wr_sre)
        srq_enable <= wr_data[7:0];
    end
  end

  assign esb_sum = |(event_status & event_status_enable);

  scpi_status_group #(
    .WIDTH (16),
    .USED  (`QUES_USED_MASK)
  ) u_ques (
    .core_clk   (core_clk),
    .rst        (rst || clear_status),
    .cond_in    (16'h0000),
    .wr_enable  (wr_ques_en),
    .wr_ptr     (wr_ques_ptr),
    .wr_ntr     (wr_ques_ntr),
    .wr_data    (wr_data),
    .rd_event   (rd_ques_ev),
    .cond       (ques_cond),
    .event_bits (ques_event),
    .enable     (ques_enable),
    .ptr        (ques_ptr),
    .ntr        (ques_ntr),
    .sum        (ques_sum)
  );

  assign oper_cond_in = {12'h000, sweeping, 2'b00, calibrating};

  scpi_status_group #(
    .WIDTH (16),
    .USED  (`OPER_USED_MASK)
  ) u_oper (
    .core_clk   (core_clk),
    .rst        (rst),
    .cond_in    (oper_cond_in),
    .wr_enable  (wr_oper_en),
    .wr_ptr     (wr_oper_ptr),
    .wr_ntr     (wr_oper_ntr),
    .wr_data    (wr_data),
    .rd_event   (rd_oper_ev),
    .cond       (oper_cond),
    .event_bits (oper_event),
    .enable     (oper_enable),
    .ptr        (oper_ptr),
    .ntr        (oper_ntr),
    .sum        (oper_sum)
  );

  always @* begin
    next_status_byte = 8'h00;
    next_status_byte[`STB_ERR_QUEUE] = err_queue_nonempty;
    next_status_byte[`STB_QUES_SUM]  = ques_sum;
    next_status_byte[`STB_MSG_AVAIL] = msg_available;
    next_status_byte[`STB_ESB_SUM]   = esb_sum;
    next_status_byte[`STB_OPER_SUM]  = oper_sum;
    // Bit 6 enable is masked off so the summary never feeds itself
    next_status_byte[`STB_MASTER_SUM] =
      |(next_status_byte & srq_enable & ~(8'h01 << `STB_MASTER_SUM));
  end

  // Only error queue, message and event summary may ask for service
  assign srq_sources = next_status_byte & srq_enable & `SRQ_SOURCE_MASK;

  // Status byte and request are registered, so a clear shows one cycle later
  always @(posedge core_clk) begin
    if (rst) begin
      status_byte <= 8'h00;
      srq         <= 1'b0;
    end else begin
      status_byte <= next_status_byte;
      // The request line is the only output the device raises on its own
      srq <= |srq_sources;
    end
  end

  always @* begin
    case (reg_sel)
      `SEL_ESR:         next_rd_data = {8'h00, event_status};
      `SEL_ESE:         next_rd_data = {8'h00, event_status_enable};
      `SEL_STB:         next_rd_data = {8'h00, next_status_byte};
      `SEL_SRE:         next_rd_data = {8'h00, srq_enable & 8'hbf};
      `SEL_QUES_COND:   next_rd_data = ques_cond;
      `SEL_QUES_EVENT:  next_rd_data = ques_event;
      `SEL_QUES_ENABLE: next_rd_data = ques_enable;
      `SEL_QUES_PTR:    next_rd_data = ques_ptr;
      `SEL_QUES_NTR:    next_rd_data = ques_ntr;
      `SEL_OPER_COND:   next_rd_data = oper_cond;
      `SEL_OPER_EVENT:  next_rd_data = oper_event;
      `SEL_OPER_ENABLE: next_rd_data = oper_enable;
      `SEL_OPER_PTR:    next_rd_data = oper_ptr;
      `SEL_OPER_NTR:    next_rd_data = oper_ntr;
      default:          next_rd_data = 16'h0000;
    endcase
  end

  // A serial poll answers exactly as a status byte query
  always @(posedge core_clk) begin
    if (rst) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_strobe || serial_poll;
      if (serial_poll)
        rd_data <= {8'h00, next_status_byte};
      else if (rd_strobe)
        rd_data <= next_rd_data;
    end
  end
endmodule

/* shared/status_event_reporting_consts.vh */
// Bit positions, reset values and query selectors of the status reporting block
`ifndef STATUS_EVENT_REPORTING_CONSTS_VH
`define STATUS_EVENT_REPORTING_CONSTS_VH
`define ESB_OP_COMPLETE      0
`define ESB_QUERY_ERROR      2
`define ESB_DEVICE_ERROR     3
`define ESB_EXEC_ERROR       4
`define ESB_CMD_ERROR        5
`define ESB_USER_REQUEST     6
`define ESB_POWER_ON         7
`define ES_USED_MASK         8'hfd
`define OPER_CALIBRATING     0
`define OPER_SWEEPING        3
`define OPER_USED_MASK       16'h0009
`define QUES_USED_MASK       16'h0000
`define STB_ERR_QUEUE        2
`define STB_QUES_SUM         3
`define STB_MSG_AVAIL        4
`define STB_ESB_SUM          5
`define STB_MASTER_SUM       6
`define STB_OPER_SUM         7
`define SRQ_SOURCE_MASK      8'h34
`define RESET_ENABLE8        8'h00
`define RESET_ENABLE16       16'h0000
`define RESET_PTR16          16'hffff
`define RESET_NTR16          16'h0000
`define SEL_ESR              4'h0
`define SEL_ESE              4'h1
`define SEL_STB              4'h2
`define SEL_SRE              4'h3
`define SEL_QUES_COND        4'h4
`define SEL_QUES_EVENT       4'h5
`define SEL_QUES_ENABLE      4'h6
`define SEL_QUES_PTR         4'h7
`define SEL_QUES_NTR         4'h8
`define SEL_OPER_COND        4'h9
`define SEL_OPER_EVENT       4'ha
`define SEL_OPER_ENABLE      4'hb
`define SEL_OPER_PTR         4'hc
`define SEL_OPER_NTR         4'hd
`endif

/* tb/remote_controller_model.sv */
// Remote controller model issuing register writes and reads
`timescale 1ns/10ps
module remote_controller_model (
  input wire         core_clk,
  output logic       wr_strobe,
  output logic       rd_strobe,
  output logic [3:0] reg_sel,
  output logic [15:0] wr_data
);
  initial begin
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    reg_sel = 4'h0;
    wr_data = 16'h0000;
  end
  // Every register access starts here, never from the device; serial polls are driven by the bench
  task automatic access(input logic wr, input logic [3:0] sel, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    wr_strobe = wr;
    rd_strobe = !wr;
    reg_sel = sel;
    wr_data = d;
    @(posedge core_clk);
    #1;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    // Released lines must not keep the last value
    reg_sel = ~sel;
    wr_data = ~d;
  endtask
endmodule

/* tb/status_event_reporting_props.sv */
// Port-level checks of the status reporting block
`timescale 1ns/10ps
`include "status_event_reporting_consts.vh"
module status_event_reporting_props (
  input wire       core_clk,
  input wire       rst,
  input wire       opc_request,
  input wire       cmds_idle,
  input wire       clear_status,
  input wire       err_queue_nonempty,
  input wire       msg_available,
  input wire       rd_strobe,
  input wire       rd_valid,
  input wire       srq,
  input wire [7:0] status_byte,
  input wire       opc_pending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_read;
    rd_strobe ##1 rd_valid;
  endsequence
  sequence s_opc_wait;
    opc_request && !cmds_idle && !clear_status;
  endsequence
  property p_read; rd_strobe |-> s_read; endproperty
  property p_opc_wait; s_opc_wait |=> opc_pending; endproperty
  property p_opc_hold; opc_pending && !cmds_idle && !clear_status |=> opc_pending; endproperty
  property p_opc_done; opc_pending && cmds_idle && !opc_request |=> !opc_pending; endproperty
  property p_srq; srq |-> |(status_byte & `SRQ_SOURCE_MASK); endproperty
  property p_mss; status_byte[6] |-> |(status_byte & 8'hbf); endproperty
  // Source levels land in the status byte one cycle later
  property p_err; !$past(rst) |-> status_byte[2] == $past(err_queue_nonempty); endproperty
  property p_mav; !$past(rst) |-> status_byte[4] == $past(msg_available); endproperty
  a_read: assert property (p_read) else $error("read not answered");
  a_opc_wait: assert property (p_opc_wait) else $error("opc not pending");
  a_opc_hold: assert property (p_opc_hold) else $error("opc dropped early");
  a_opc_done: assert property (p_opc_done) else $error("opc not completed");
  a_srq: assert property (p_srq) else $error("srq without source");
  a_mss: assert property (p_mss) else $error("master summary alone");
  a_err: assert property (p_err) else $error("error queue bit wrong");
  a_mav: assert property (p_mav) else $error("message bit wrong");
endmodule

/* tb/test_status_event_reporting.sv */
// Self-checking bench for the status reporting block
`timescale 1ns/10ps
`include "status_event_reporting_consts.vh"
module test_status_event_reporting;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        opc_request = 1'b0;
  logic        cmds_idle = 1'b1;
  logic [5:0]  ev = 6'h00;
  logic        err_q = 1'b0;
  logic        msg_av = 1'b0;
  logic        calibrating = 1'b0;
  logic        sweeping = 1'b0;
  logic        clear_status = 1'b0;
  logic        serial_poll = 1'b0;
  logic        wr_strobe, rd_strobe, rd_valid, srq, opc_pending;
  logic [3:0]  reg_sel;
  logic [15:0] wr_data, rd_data;
  logic [7:0]  status_byte;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h00015c36;
  int          num_errors = 0;
  int          total_checks = 0;
  always #4 core_clk = ~core_clk;
  status_event_reporting i_status_event_reporting (
    .core_clk, .rst, .opc_request, .cmds_idle,
    .query_error(ev[0]), .device_error(ev[1]), .exec_error(ev[2]),
    .cmd_error(ev[3]), .go_local(ev[4]), .power_on(ev[5]),
    .err_queue_nonempty(err_q), .msg_available(msg_av), .calibrating, .sweeping,
    .clear_status, .serial_poll, .wr_strobe, .rd_strobe, .reg_sel, .wr_data,
    .rd_data, .rd_valid, .srq, .status_byte, .opc_pending);
  remote_controller_model i_remote_controller_model (
    .core_clk, .wr_strobe, .rd_strobe, .reg_sel, .wr_data);
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] sel, input logic [15:0] e);
    exp_q.push_back(e);
    i_remote_controller_model.access(1'b0, sel, 16'h0000);
  endtask
  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    i_remote_controller_model.access(1'b1, sel, d);
  endtask
  task automatic pulse(input logic [5:0] v);
    step(1);
    ev = v;
    step(1);
    ev = 6'h00;
  endtask
  // Read answers are matched in order against the noted values
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 16'h0000, rd_data);
      else check("rd_data", exp_q.pop_front(), rd_data);
    end
  end
  initial begin
    #20000;
    num_errors++;
    final_report;
  end
  initial begin
    step(2);
    rst = 1'b0;
    rd(`SEL_ESE, 16'h0000);
    rd(`SEL_OPER_PTR, 16'h0009);
    rd(4'he, 16'h0000);
    wr(`SEL_QUES_ENABLE, 16'hffff);
    rd(`SEL_QUES_ENABLE, 16'h0000);
    rd(`SEL_QUES_COND, 16'h0000);
    wr(`SEL_ESE, 16'hffff);
    rd(`SEL_ESE, 16'h00fd);
    repeat (4) begin
      seed = xorshift(seed);
      pulse(seed[5:0]);
      step(1);
      check("esb", {15'h0, |seed[5:0]}, {15'h0, status_byte[5]});
      rd(`SEL_ESR, {8'h00, seed[5:0], 2'b00});
      rd(`SEL_ESR, 16'h0000);
    end
    wr(`SEL_ESE, 16'h0001);
    wr(`SEL_SRE, 16'h0020);
    step(1);
    cmds_idle = 1'b0;
    opc_request = 1'b1;
    step(1);
    opc_request = 1'b0;
    step(3);
    check("srq", 16'h0000, {15'h0, srq});
    cmds_idle = 1'b1;
    step(2);
    check("srq", 16'h0001, {15'h0, srq});
    rd(`SEL_ESR, 16'h0001);
    step(2);
    check("srq", 16'h0000, {15'h0, srq});
    wr(`SEL_OPER_ENABLE, 16'hffff);
    wr(`SEL_SRE, 16'h00b4);
    step(1);
    calibrating = 1'b1;
    rd(`SEL_OPER_COND, 16'h0001);
    check("oper sum", 16'h0001, {15'h0, status_byte[7]});
    check("srq", 16'h0000, {15'h0, srq});
    rd(`SEL_OPER_ENABLE, 16'h0009);
    rd(`SEL_OPER_EVENT, 16'h0001);
    rd(`SEL_OPER_EVENT, 16'h0000);
    calibrating = 1'b0;
    sweeping = 1'b1;
    rd(`SEL_OPER_COND, 16'h0008);
    rd(`SEL_OPER_EVENT, 16'h0008);
    err_q = 1'b1;
    step(2);
    check("srq", 16'h0001, {15'h0, srq});
    exp_q.push_back(16'h0044);
    serial_poll = 1'b1;
    step(1);
    serial_poll = 1'b0;
    rd(`SEL_STB, 16'h0044);
    err_q = 1'b0;
    msg_av = 1'b1;
    step(2);
    check("srq", 16'h0001, {15'h0, srq});
    msg_av = 1'b0;
    step(2);
    check("srq", 16'h0000, {15'h0, srq});
    pulse(6'h20);
    clear_status = 1'b1;
    step(1);
    clear_status = 1'b0;
    rd(`SEL_ESR, 16'h0000);
    step(3);
    final_report;
  end
endmodule
bind status_event_reporting status_event_reporting_props i_status_event_reporting_props (
  .core_clk, .rst, .opc_request, .cmds_idle, .clear_status, .err_queue_nonempty,
  .msg_available, .rd_strobe, .rd_valid, .srq, .status_byte, .opc_pending);
